//--- logic/biex_pkg.sv
package biex_pkg;
  // Widths
  localparam int PC_W    = 21;
  localparam int DADDR_W = 12;
  localparam int BANK_W  = 4;

  // Register byte offsets
  localparam logic [7:0] REG_CTRL  = 8'h00;
  localparam logic [7:0] REG_BANK  = 8'h04;
  localparam logic [7:0] REG_WORK  = 8'h08;
  localparam logic [7:0] REG_FLAGS = 8'h0c;
  localparam logic [7:0] REG_PC    = 8'h10;
  localparam logic [7:0] REG_INDEX = 8'h14;

  // Control field positions
  localparam int CTRL_RUN_BIT = 0;
  localparam int CTRL_EXT_BIT = 1;
  localparam int CTRL_ST_LSB  = 4;

  // Flag field positions
  localparam int FLG_C  = 0;
  localparam int FLG_DC = 1;
  localparam int FLG_Z  = 2;
  localparam int FLG_OV = 3;
  localparam int FLG_N  = 4;
  localparam int FLG_W  = 5;

  // Values after reset
  localparam logic [1:0]         CTRL_RST  = 2'h0;
  localparam logic [BANK_W-1:0]  BANK_RST  = 4'h0;
  localparam logic [7:0]         WORK_RST  = 8'h00;
  localparam logic [FLG_W-1:0]   FLAGS_RST = 5'h00;
  localparam logic [PC_W-1:0]    PC_RST    = 21'h000000;
  localparam logic [DADDR_W-1:0] INDEX_RST = 12'h000;

  // Opcodes and addressing constants
  localparam logic [7:0]  OP_BRANCH1 = 8'hef;
  localparam logic [3:0]  OP_BRANCH2 = 4'hf;
  localparam logic [5:0]  OP_INC     = 6'h0a;
  localparam logic [5:0]  OP_INCSZ   = 6'h0f;
  localparam logic [7:0]  ILO_MAX    = 8'h5f;
  localparam logic [7:0]  ACC_SPLIT  = 8'h60;
  localparam logic [3:0]  SFR_BANK   = 4'hf;
  localparam logic [PC_W-1:0] PC_STEP = 21'h000002;

  // Quarter-cycle phases
  localparam logic [1:0] Q1 = 2'h0;
  localparam logic [1:0] Q2 = 2'h1;
  localparam logic [1:0] Q3 = 2'h2;
  localparam logic [1:0] Q4 = 2'h3;

  typedef enum logic [1:0] {
    BIEX_EXEC  = 2'b00,
    BIEX_BR2   = 2'b01,
    BIEX_SKIP  = 2'b10,
    BIEX_SKIP2 = 2'b11
  } biex_state_e;
endpackage

//--- logic/biex_q_if.sv
`timescale 1ns/1ps
interface biex_q_if;
  logic       run;
  logic       q_stb;
  logic [1:0] q_phase;
  modport gen (input run, output q_stb, output q_phase);
  modport use_q (output run, input q_stb, input q_phase);
endinterface

//--- logic/biex_qdiv.sv
`timescale 1ns/1ps
module biex_qdiv #(
  parameter int QDIV = 1
) (
  input  wire logic CORE_CLK_I,
  input  wire logic RESET_I,
  biex_q_if.gen     q
);
  logic [15:0] div_ff;
  logic [15:0] nxt_div;
  logic [1:0]  phase_ff;
  logic [1:0]  nxt_phase;
  logic        stb;

  // One enable pulse per quarter cycle
  assign stb = q.run && (div_ff == 16'(QDIV - 1));

  always_comb begin
    nxt_div   = div_ff;
    nxt_phase = phase_ff;
    if (!q.run) begin
      nxt_div   = 16'h0000;
      nxt_phase = biex_pkg::Q1;
    end else if (stb) begin
      nxt_div   = 16'h0000;
      nxt_phase = phase_ff + 2'h1;
    end else begin
      nxt_div = div_ff + 16'h0001;
    end
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (RESET_I) begin
      div_ff   <= 16'h0000;
      phase_ff <= biex_pkg::Q1;
    end else begin
      div_ff   <= nxt_div;
      phase_ff <= nxt_phase;
    end
  end

  assign q.q_stb   = stb;
  assign q.q_phase = phase_ff;
endmodule // biex_qdiv

//--- logic/biex_top.sv
// Function
// - Branch loads 20-bit target into PC<20:1>
// - Branch reaches whole space, flags untouched
// - Branch is two words, two cycles
// - Branch Q-activity; second cycle is idle
// - Increment adds one, routes, sets flags
// - Access bit picks access bank or bank
// - Indexed literal offset for low addresses
// - Increment-skip leaves flags, skips on zero
// - Skip discards fetched word, executes idle
`timescale 1ns/1ps
module biex_top #(
  parameter int QDIV = 1
) (
  input  wire logic                         CORE_CLK_I,
  input  wire logic                         RESET_I,
  input  wire logic                         PSEL_I,
  input  wire logic                         PENABLE_I,
  input  wire logic                         PWRITE_I,
  input  wire logic [7:0]                   PADDR_I,
  input  wire logic [31:0]                  PWDATA_I,
  output      logic [31:0]                  PRDATA_O,
  output      logic                         PREADY_O,
  output      logic                         PSLVERR_O,
  output      logic [biex_pkg::PC_W-1:0]    PROG_ADDR_O,
  input  wire logic [15:0]                  PROG_DATA_I,
  output      logic [biex_pkg::DADDR_W-1:0] DMEM_ADDR_O,
  input  wire logic [7:0]                   DMEM_RDATA_I,
  output      logic [7:0]                   DMEM_WDATA_O,
  output      logic                         DMEM_WE_O
);
  biex_q_if q_bus ();

  biex_qdiv #(.QDIV(QDIV)) u_qdiv (
    .CORE_CLK_I (CORE_CLK_I),
    .RESET_I    (RESET_I),
    .q          (q_bus.gen)
  );

  biex_pkg::biex_state_e            state_ff, nxt_state;
  logic [1:0]                       ctrl_ff, nxt_ctrl;
  logic [biex_pkg::BANK_W-1:0]      bank_ff, nxt_bank;
  logic [7:0]                       work_ff, nxt_work;
  logic [biex_pkg::FLG_W-1:0]       flags_ff, nxt_flags;
  logic [biex_pkg::PC_W-1:0]        pc_ff, nxt_pc;
  logic [biex_pkg::DADDR_W-1:0]     index_ff, nxt_index;
  logic [15:0]                      ir_ff, nxt_ir;
  logic [7:0]                       klo_ff, nxt_klo;
  logic [7:0]                       opnd_ff, nxt_opnd;
  logic [7:0]                       res_ff, nxt_res;
  logic [biex_pkg::DADDR_W-1:0]     daddr_ff, nxt_daddr;
  logic [biex_pkg::PC_W-1:0]        paddr_ff, nxt_paddr;
  logic [31:0]                      prdata_ff, nxt_prdata;
  logic                             slverr_ff, nxt_slverr;

  logic       q1, q2, q3, q4;
  logic       is_inc, is_incsz, is_br;
  logic       apb_wr, apb_rd, hit;

  // Words that occupy two program locations
  function automatic logic two_word(input logic [15:0] w);
    two_word = (w[15:12] == 4'hc) || (w[15:9] == 7'h76) ||
               (w[15:8] == 8'hee && w[7:6] == 2'h0) ||
               (w[15:8] == biex_pkg::OP_BRANCH1);
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == biex_pkg::REG_CTRL)  || (a == biex_pkg::REG_BANK) ||
             (a == biex_pkg::REG_WORK)  || (a == biex_pkg::REG_FLAGS) ||
             (a == biex_pkg::REG_PC)    || (a == biex_pkg::REG_INDEX);
  endfunction

  // Operand address from access bit, bank and index
  function automatic logic [biex_pkg::DADDR_W-1:0] op_addr(
    input logic [15:0]                  w,
    input logic                         ext,
    input logic [biex_pkg::BANK_W-1:0]  bank,
    input logic [biex_pkg::DADDR_W-1:0] index
  );
    logic [7:0] f;
    f = w[7:0];
    if (w[8]) begin
      op_addr = {bank, f};
    end else if (ext && f <= biex_pkg::ILO_MAX) begin
      op_addr = index + {4'h0, f};
    end else if (f >= biex_pkg::ACC_SPLIT) begin
      op_addr = {biex_pkg::SFR_BANK, f};
    end else begin
      op_addr = {4'h0, f};
    end
  endfunction

  assign q_bus.run = ctrl_ff[biex_pkg::CTRL_RUN_BIT];
  assign q1 = q_bus.q_stb && q_bus.q_phase == biex_pkg::Q1;
  assign q2 = q_bus.q_stb && q_bus.q_phase == biex_pkg::Q2;
  assign q3 = q_bus.q_stb && q_bus.q_phase == biex_pkg::Q3;
  assign q4 = q_bus.q_stb && q_bus.q_phase == biex_pkg::Q4;

  assign is_br    = state_ff == biex_pkg::BIEX_EXEC && ir_ff[15:8] == biex_pkg::OP_BRANCH1;
  assign is_inc   = state_ff == biex_pkg::BIEX_EXEC && ir_ff[15:10] == biex_pkg::OP_INC;
  assign is_incsz = state_ff == biex_pkg::BIEX_EXEC && ir_ff[15:10] == biex_pkg::OP_INCSZ;

  assign apb_wr = PSEL_I && PENABLE_I && PWRITE_I;
  assign apb_rd = PSEL_I && !PENABLE_I && !PWRITE_I;
  assign hit    = mapped(PADDR_I);

  always_comb begin
    nxt_state  = state_ff;
    nxt_ctrl   = ctrl_ff;
    nxt_bank   = bank_ff;
    nxt_work   = work_ff;
    nxt_flags  = flags_ff;
    nxt_pc     = pc_ff;
    nxt_index  = index_ff;
    nxt_ir     = ir_ff;
    nxt_klo    = klo_ff;
    nxt_opnd   = opnd_ff;
    nxt_res    = res_ff;
    nxt_daddr  = daddr_ff;
    nxt_paddr  = paddr_ff;
    nxt_prdata = prdata_ff;
    nxt_slverr = 1'b0;

    // Register writes; execution below overrides in the same cycle
    if (apb_wr && hit) begin
      if (PADDR_I == biex_pkg::REG_CTRL) begin
        nxt_ctrl = PWDATA_I[1:0];
      end else if (PADDR_I == biex_pkg::REG_BANK) begin
        nxt_bank = PWDATA_I[biex_pkg::BANK_W-1:0];
      end else if (PADDR_I == biex_pkg::REG_WORK) begin
        nxt_work = PWDATA_I[7:0];
      end else if (PADDR_I == biex_pkg::REG_FLAGS) begin
        nxt_flags = PWDATA_I[biex_pkg::FLG_W-1:0];
      end else if (PADDR_I == biex_pkg::REG_PC) begin
        nxt_pc    = {PWDATA_I[biex_pkg::PC_W-1:1], 1'b0};
        nxt_paddr = {PWDATA_I[biex_pkg::PC_W-1:1], 1'b0};
      end else begin
        nxt_index = PWDATA_I[biex_pkg::DADDR_W-1:0];
      end
    end
    if (PSEL_I && !PENABLE_I) begin
      nxt_slverr = !hit;
    end else if (PSEL_I) begin
      nxt_slverr = slverr_ff;
    end
    if (apb_rd) begin
      if (PADDR_I == biex_pkg::REG_CTRL) begin
        nxt_prdata = {26'h0, state_ff, 2'h0, ctrl_ff};
      end else if (PADDR_I == biex_pkg::REG_BANK) begin
        nxt_prdata = {28'h0, bank_ff};
      end else if (PADDR_I == biex_pkg::REG_WORK) begin
        nxt_prdata = {24'h0, work_ff};
      end else if (PADDR_I == biex_pkg::REG_FLAGS) begin
        nxt_prdata = {27'h0, flags_ff};
      end else if (PADDR_I == biex_pkg::REG_PC) begin
        nxt_prdata = {11'h0, pc_ff};
      end else if (PADDR_I == biex_pkg::REG_INDEX) begin
        nxt_prdata = {20'h0, index_ff};
      end else begin
        nxt_prdata = 32'h0;
      end
    end

    case (state_ff)
      biex_pkg::BIEX_EXEC: begin
        if (q1) begin
          nxt_ir = PROG_DATA_I;
          nxt_daddr = op_addr(PROG_DATA_I, ctrl_ff[biex_pkg::CTRL_EXT_BIT],
                              bank_ff, index_ff);
        end
        // low literal and second word fetch
        if (q2 && is_br) begin
          nxt_klo   = ir_ff[7:0];
          nxt_paddr = pc_ff + biex_pkg::PC_STEP;
        end
        if (q2 && (is_inc || is_incsz)) begin
          nxt_opnd = DMEM_RDATA_I;
        end
        if (q3 && (is_inc || is_incsz)) begin
          nxt_res = opnd_ff + 8'h01;
          if (is_inc) begin
            nxt_flags[biex_pkg::FLG_C]  = opnd_ff == 8'hff;
            nxt_flags[biex_pkg::FLG_DC] = opnd_ff[3:0] == 4'hf;
            nxt_flags[biex_pkg::FLG_Z]  = opnd_ff == 8'hff;
            nxt_flags[biex_pkg::FLG_OV] = opnd_ff == 8'h7f;
            nxt_flags[biex_pkg::FLG_N]  = opnd_ff[7:0] + 8'h01 >= 8'h80;
          end
        end
        if (q4) begin
          if (is_br) begin
            nxt_pc    = {PROG_DATA_I[11:0], klo_ff, 1'b0};
            nxt_paddr = {PROG_DATA_I[11:0], klo_ff, 1'b0};
            nxt_state = biex_pkg::BIEX_BR2;
          end else begin
            nxt_pc    = pc_ff + biex_pkg::PC_STEP;
            nxt_paddr = pc_ff + biex_pkg::PC_STEP;
            if ((is_inc || is_incsz) && !ir_ff[9]) begin
              nxt_work = res_ff;
            end
            if (is_incsz && res_ff == 8'h00) begin
              nxt_state = biex_pkg::BIEX_SKIP;
            end
          end
        end
      end
      biex_pkg::BIEX_BR2: begin
        if (q4) begin
          nxt_state = biex_pkg::BIEX_EXEC;
        end
      end
      biex_pkg::BIEX_SKIP: begin
        if (q1) begin
          nxt_ir = PROG_DATA_I;
        end
        if (q4) begin
          nxt_pc    = pc_ff + biex_pkg::PC_STEP;
          nxt_paddr = pc_ff + biex_pkg::PC_STEP;
          nxt_state = two_word(ir_ff) ? biex_pkg::BIEX_SKIP2 : biex_pkg::BIEX_EXEC;
        end
      end
      biex_pkg::BIEX_SKIP2: begin
        if (q4) begin
          nxt_pc    = pc_ff + biex_pkg::PC_STEP;
          nxt_paddr = pc_ff + biex_pkg::PC_STEP;
          nxt_state = biex_pkg::BIEX_EXEC;
        end
      end
      default: begin
        nxt_state = biex_pkg::BIEX_EXEC;
      end
    endcase
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (RESET_I) begin
      state_ff  <= biex_pkg::BIEX_EXEC;
      ctrl_ff   <= biex_pkg::CTRL_RST;
      bank_ff   <= biex_pkg::BANK_RST;
      work_ff   <= biex_pkg::WORK_RST;
      flags_ff  <= biex_pkg::FLAGS_RST;
      pc_ff     <= biex_pkg::PC_RST;
      index_ff  <= biex_pkg::INDEX_RST;
      ir_ff     <= 16'h0000;
      klo_ff    <= 8'h00;
      opnd_ff   <= 8'h00;
      res_ff    <= 8'h00;
      daddr_ff  <= 12'h000;
      paddr_ff  <= biex_pkg::PC_RST;
      prdata_ff <= 32'h0;
      slverr_ff <= 1'b0;
    end else begin
      state_ff  <= nxt_state;
      ctrl_ff   <= nxt_ctrl;
      bank_ff   <= nxt_bank;
      work_ff   <= nxt_work;
      flags_ff  <= nxt_flags;
      pc_ff     <= nxt_pc;
      index_ff  <= nxt_index;
      ir_ff     <= nxt_ir;
      klo_ff    <= nxt_klo;
      opnd_ff   <= nxt_opnd;
      res_ff    <= nxt_res;
      daddr_ff  <= nxt_daddr;
      paddr_ff  <= nxt_paddr;
      prdata_ff <= nxt_prdata;
      slverr_ff <= nxt_slverr;
    end
  end

  // write back to register in Q4
  assign DMEM_WE_O    = q4 && (is_inc || is_incsz) && ir_ff[9];
  assign DMEM_WDATA_O = res_ff;
  assign DMEM_ADDR_O  = daddr_ff;
  assign PROG_ADDR_O  = paddr_ff;
  assign PRDATA_O     = prdata_ff;
  assign PSLVERR_O    = slverr_ff && PSEL_I && PENABLE_I;
  assign PREADY_O     = 1'b1;
endmodule // biex_top

//--- verification/biex_mem_model.sv
`timescale 1ns/1ps
module biex_mem_model (
  input  wire logic        clk_i,
  input  wire logic [20:0] prog_addr_i,
  output      logic [15:0] prog_data_o,
  input  wire logic [11:0] dmem_addr_i,
  output      logic [7:0]  dmem_rdata_o,
  input  wire logic [7:0]  dmem_wdata_i,
  input  wire logic        dmem_we_i
);
  logic [15:0] pm [256];
  logic [7:0]  dm [4096];
  // Word index aliases the upper program space
  assign prog_data_o  = pm[prog_addr_i[8:1]];
  assign dmem_rdata_o = dm[dmem_addr_i];
  always @(posedge clk_i) begin
    if (dmem_we_i) begin
      dm[dmem_addr_i] <= dmem_wdata_i;
    end
  end
endmodule // biex_mem_model

//--- verification/biex_checker.sv
`timescale 1ns/1ps
module biex_checker (
  input wire logic        CORE_CLK_I,
  input wire logic        RESET_I,
  input wire logic        PSEL_I,
  input wire logic        PENABLE_I,
  input wire logic        PWRITE_I,
  input wire logic [7:0]  PADDR_I,
  input wire logic [31:0] PRDATA_O,
  input wire logic        PREADY_O,
  input wire logic        PSLVERR_O,
  input wire logic [20:0] PROG_ADDR_O,
  input wire logic [11:0] DMEM_ADDR_O,
  input wire logic [7:0]  DMEM_RDATA_I,
  input wire logic [7:0]  DMEM_WDATA_O,
  input wire logic        DMEM_WE_O
);
  default clocking @(posedge CORE_CLK_I); endclocking
  default disable iff (RESET_I);
  logic unmapped;
  assign unmapped = PADDR_I > 8'h14 || PADDR_I[1:0] != 2'h0;
  zero_wait_a: assert property (PREADY_O)
    else $error("pready low");
  err_phase_a: assert property (PSLVERR_O |-> PSEL_I && PENABLE_I)
    else $error("error outside access");
  err_decode_a: assert property (PSEL_I && PENABLE_I |-> PSLVERR_O == unmapped)
    else $error("error decode wrong");
  err_data_a: assert property (PSLVERR_O && !PWRITE_I |-> PRDATA_O == 32'h0)
    else $error("unmapped read not zero");
  pc_align_a: assert property (PROG_ADDR_O[0] == 1'b0)
    else $error("program address odd");
  we_pulse_a: assert property (DMEM_WE_O |=> !DMEM_WE_O [*3])
    else $error("write not one per cycle");
  inc_sum_a: assert property (DMEM_WE_O |-> DMEM_WDATA_O == $past(DMEM_RDATA_I, 2) + 8'h01)
    else $error("write data not read plus one");
  addr_hold_a: assert property (DMEM_WE_O |-> $past(DMEM_ADDR_O, 2) == DMEM_ADDR_O)
    else $error("data address moved");
  reset_idle_a: assert property (disable iff (1'b0)
    RESET_I |=> !DMEM_WE_O && !PSLVERR_O && PROG_ADDR_O == 21'h0)
    else $error("outputs not idle after reset");
endmodule // biex_checker
bind biex_top biex_checker chk (.*);

//--- verification/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic clk, rst, psel, pen, pwr, pready, pslverr, dwe;
  logic [7:0] paddr, drd, dwd;
  logic [31:0] pwdata, prdata;
  logic [20:0] pa;
  logic [15:0] pd;
  logic [11:0] da;
  logic far;
  int n_errors, total_checks;
  localparam logic [19:0] K = 20'habc80;

  biex_top dut (.CORE_CLK_I(clk), .RESET_I(rst), .PSEL_I(psel), .PENABLE_I(pen),
    .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
    .PREADY_O(pready), .PSLVERR_O(pslverr), .PROG_ADDR_O(pa), .PROG_DATA_I(pd),
    .DMEM_ADDR_O(da), .DMEM_RDATA_I(drd), .DMEM_WDATA_O(dwd), .DMEM_WE_O(dwe));
  biex_mem_model mm (.clk_i(clk), .prog_addr_i(pa), .prog_data_o(pd),
    .dmem_addr_i(da), .dmem_rdata_o(drd), .dmem_wdata_i(dwd), .dmem_we_i(dwe));

  always #5 clk = ~clk;
  always @(posedge clk) if (pa === {K, 1'b0}) far <= 1'b1;

  task automatic test_done();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] x);
    total_checks++;
    if (s !== x) begin
      n_errors++;
      $display("MISMATCH %s exp %h seen %h", nm, x, s);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n == 50) n_errors++;
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    logic e;
    apb(1'b0, a, 32'h0, r, e);
  endtask
  task automatic run(input logic e);
    wr(biex_pkg::REG_PC, 32'h0);
    far = 1'b0;
    wr(biex_pkg::REG_CTRL, {30'h0, e, 1'b1});
    repeat (80) @(posedge clk);
    wr(biex_pkg::REG_CTRL, {30'h0, e, 1'b0});
  endtask
  function automatic logic [11:0] ea(logic a, logic e, logic [7:0] f, logic [3:0] b,
                                     logic [11:0] ix);
    if (a) return {b, f};
    if (e && f <= 8'h5f) return ix + {4'h0, f};
    return f < 8'h60 ? {4'h0, f} : {4'hf, f};
  endfunction
  function automatic logic [4:0] fl(logic [7:0] s);
    logic [7:0] q;
    q = s + 8'h01;
    return {q[7], s == 8'h7f, s == 8'hff, s[3:0] == 4'hf, s == 8'hff};
  endfunction

  initial begin
    logic [31:0] r;
    logic [7:0] s, f, q, w0, g;
    logic [3:0] b;
    logic [11:0] ix, ad;
    logic d, a, e, er, sk;
    logic [4:0] fw;
    clk = 0;
    rst = 1;
    psel = 0;
    pen = 0;
    pwr = 0;
    paddr = 0;
    pwdata = 0;
    far = 0;
    void'($urandom(32'h2365));
    repeat (6) @(posedge clk);
    rst <= 0;
    @(posedge clk);
    for (int i = 0; i < 6; i++) begin
      rd(8'(i * 4), r);
      chk("reset value", r, 32'h0);
    end
    apb(1'b0, 8'h18, 32'h0, r, er);
    chk("unmapped err", er, 1'b1);
    chk("unmapped data", r, 32'h0);
    foreach (mm.pm[i]) mm.pm[i] = 16'h0000;
    for (int i = 0; i < 24; i++) begin
      s = i < 4 ? 8'hff >> (i * 2) : 8'($urandom);
      if (i == 1) s = 8'h7f;
      f = i == 4 ? 8'h5f : i == 5 ? 8'h60 : 8'($urandom);
      {d, a, e, b, ix, w0} = 27'($urandom);
      if (i == 4 || i == 5) {a, e} = 2'b01;
      wr(biex_pkg::REG_BANK, 32'(b));
      wr(biex_pkg::REG_INDEX, 32'(ix));
      wr(biex_pkg::REG_WORK, 32'(w0));
      ad = ea(a, e, f, b, ix);
      mm.dm[ad] = s;
      mm.pm[0] = {biex_pkg::OP_INC, d, a, f};
      mm.pm[1] = 16'hef01;
      mm.pm[2] = 16'hf000;
      run(e);
      q = s + 8'h01;
      rd(biex_pkg::REG_WORK, r);
      chk("work", r, d ? w0 : q);
      chk("data", mm.dm[ad], d ? q : s);
      rd(biex_pkg::REG_FLAGS, r);
      chk("flags", r, 32'(fl(s)));
    end
    for (int j = 0; j < 4; j++) begin
      s = j == 0 ? 8'hff : 8'($urandom);
      {g, fw} = 13'($urandom);
      sk = s == 8'hff;
      wr(biex_pkg::REG_BANK, 32'h3);
      wr(biex_pkg::REG_FLAGS, 32'(fw));
      mm.dm[12'h320] = s;
      mm.dm[12'h321] = g;
      mm.pm[0] = {biex_pkg::OP_INCSZ, 2'b11, 8'h20};
      mm.pm[1] = 16'hef80;
      mm.pm[2] = {4'hf, K[19:8]};
      mm.pm[3] = 16'hef03;
      mm.pm[4] = 16'hf000;
      mm.pm[128] = {biex_pkg::OP_INC, 2'b11, 8'h21};
      mm.pm[129] = 16'hef81;
      mm.pm[130] = {4'hf, K[19:8]};
      run(1'b0);
      q = s + 8'h01;
      chk("skip data", mm.dm[12'h320], q);
      chk("far target", far, !sk);
      chk("after skip", mm.dm[12'h321], sk ? g : 8'(g + 8'h01));
      rd(biex_pkg::REG_FLAGS, r);
      chk("skip flags", r, sk ? 32'(fw) : 32'(fl(g)));
    end
    test_done();
  end
  initial begin
    repeat (30000) @(posedge clk);
    n_errors++;
    test_done();
  end
endmodule // tb_top
